// ==== rpd_pkg.sv ====
/*
 * Shared constants, register indices, field positions and carrier
 * structs for the reactive power datapath.
 * Assumes one 10 MHz clock and a 32-bit AXI4-Lite register bus.
 */
package rpd_pkg;
	localparam int CLK_HZ = 10_000_000;
	localparam int WAVE_BASE_SPS = 25_600;
	localparam int WAVE_BASE_DIV = CLK_HZ / WAVE_BASE_SPS;
	localparam logic [8:0] WAVE_BASE_LAST = 9'(WAVE_BASE_DIV - 1);

	localparam int SMP_W = 24;
	localparam int PWR_W = 32;
	localparam int AXI_AW = 12;

	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_WAVE_SRC = 8'h0d;
	localparam logic [7:0] IDX_NL_MODE = 8'h0e;
	localparam logic [7:0] IDX_ACC_MODE = 8'h0f;
	localparam logic [7:0] IDX_GAIN = 8'h1e;
	localparam logic [7:0] IDX_OFFSET = 8'h21;
	localparam logic [7:0] IDX_IRQ_EN_LO = 8'hd9;
	localparam logic [7:0] IDX_IRQ_EN_HI = 8'hdb;
	localparam logic [7:0] IDX_IRQ_ST_LO = 8'hdc;
	localparam logic [7:0] IDX_CTRL = 8'h30;
	localparam logic [7:0] IDX_POWER = 8'h31;

	// field positions
	localparam int WAVE_SRC_LO = 0;
	localparam logic [2:0] WAVE_SRC_REACTIVE = 3'h5;
	localparam int WAVE_RATE_LO = 3;
	localparam int WAVE_EN_BIT = 5;
	localparam int NL_SEL_LO = 2;
	localparam int SIGN_POL_BIT = 5;
	localparam int ST_SIGN_BIT = 4;
	localparam int ST_NOLOAD_BIT = 1;
	localparam int CTRL_INTEG_BIT = 0;
	localparam logic [7:0] ST_IMPL_MASK = 8'h12;

	// values after reset
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [11:0] RST_GAIN = 12'h000;
	localparam logic [15:0] RST_OFFSET = 16'h0000;

	localparam int GAIN_FRAC = 12;
	localparam int OFFS_FRAC = 8;

	// no-load thresholds in parts per million of full scale
	localparam int NL_PPM_1 = 150;
	localparam int NL_PPM_2 = 75;
	localparam int NL_PPM_3 = 37;

	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	typedef struct packed {
		logic awvalid;
		logic [AXI_AW-1:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [AXI_AW-1:0] araddr;
		logic rready;
	} rpd_axil_req_s;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} rpd_axil_rsp_s;

	typedef struct packed {
		logic valid;
		logic signed [SMP_W-1:0] volt;
		logic signed [SMP_W-1:0] curr;
	} rpd_smp_s;

	typedef struct packed {
		logic valid;
		logic signed [PWR_W-1:0] data;
	} rpd_wave_s;
endpackage : rpd_pkg

// ==== rpd_reactive_power.sv ====
/*
 * Reactive power datapath: quarter-cycle phase shift of the current,
 * multiply by voltage, low-pass, gain and offset, waveform samples,
 * sign-change and no-load flags with masked interrupt, AXI4-Lite slave.
 * Assumes paired voltage/current samples arrive together, synchronous
 * to clk, with at least four clocks between sample strobes.
 */
// How it works
// R1: multiply voltage by quarter-cycle shifted current
// R2: low-pass product to its dc value
// R3: reactive waveform samples at selectable rates
// R4: scale by one plus gain over 4096
// R5: add signed 16-bit offset correction
// R6: offset of 256 moves output one LSB
// R7: integrator on lags, off leads, quarter cycle
// R8: positive sign for 0 to +90 degrees
// R9: sign-change flag follows chosen polarity bit
// R10: polarity clear flags positive to negative
// R11: polarity set flags negative to positive
// R12: enabled sign flag holds interrupt until cleared
// R13: block accumulation below no-load threshold
// R14: no-load flag set, interrupt while enabled
// R15: threshold select: off, 150, 75, 37 ppm
// R16: flags stay set until software clears
`timescale 1ns/1ps
module rpd_reactive_power #(
	parameter int INT_SHIFT = 6,
	parameter int LPF_SHIFT = 8,
	parameter logic [31:0] FULL_SCALE = 32'h7fffffff
) (
	input wire logic clk, // 10 MHz clock
	input wire logic srst, // synchronous reset, high
	input wire rpd_pkg::rpd_axil_req_s axiReq, // bus request
	output rpd_pkg::rpd_axil_rsp_s axiRsp, // bus response
	input wire rpd_pkg::rpd_smp_s smpIn, // channel samples
	output rpd_pkg::rpd_wave_s waveOut, // waveform samples
	output logic accumEnable, // energy may accumulate
	output logic irq // level interrupt
);
	import rpd_pkg::*;

	localparam int MW = SMP_W + PWR_W;
	localparam logic [PWR_W-1:0] THR_1 =
		PWR_W'((64'(FULL_SCALE) * NL_PPM_1) / 1_000_000);
	localparam logic [PWR_W-1:0] THR_2 =
		PWR_W'((64'(FULL_SCALE) * NL_PPM_2) / 1_000_000);
	localparam logic [PWR_W-1:0] THR_3 =
		PWR_W'((64'(FULL_SCALE) * NL_PPM_3) / 1_000_000);

	logic [7:0] waveSrc_reg;
	logic [7:0] no_load_mode_config_reg;
	logic [7:0] accumulation_mode_config_reg;
	logic [11:0] gain_reg;
	logic [15:0] offset_reg;
	logic [7:0] irqEnLo_reg;
	logic [7:0] irqEnHi_reg;
	logic [7:0] status_reg;
	logic [7:0] status_next;
	logic [7:0] ctrl_reg;

	logic awHave_reg;
	logic [AXI_AW-1:0] awAddr_reg;
	logic wHave_reg;
	logic [31:0] wData_reg;
	logic [3:0] wStrb_reg;
	logic bValid_reg;
	logic [1:0] bResp_reg;
	logic rValid_reg;
	logic [31:0] rData_reg;
	logic [1:0] rResp_reg;

	logic doWrite;
	logic wrHit;
	logic [7:0] wrIdx;
	logic [31:0] wrMask;
	logic [31:0] rdValue;
	logic rdHit;

	function automatic logic addrHit(input logic [AXI_AW-1:0] a);
		logic ok;
		ok = (a[1:0] == 2'h0);
		case (a[9:2])
			IDX_WAVE_SRC, IDX_NL_MODE, IDX_ACC_MODE, IDX_GAIN,
			IDX_OFFSET, IDX_IRQ_EN_LO, IDX_IRQ_EN_HI, IDX_IRQ_ST_LO,
			IDX_CTRL, IDX_POWER: addrHit = ok && (a[AXI_AW-1:10] == '0);
			default: addrHit = 1'b0;
		endcase
	endfunction : addrHit

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] m, input logic [31:0] d);
		merge = (old & ~m) | (d & m);
	endfunction : merge

	// bus write channels: address and data taken in either order
	assign doWrite = awHave_reg && wHave_reg && !bValid_reg;
	assign wrIdx = awAddr_reg[9:2];
	assign wrHit = addrHit(awAddr_reg);
	assign wrMask = {{8{wStrb_reg[3]}}, {8{wStrb_reg[2]}},
		{8{wStrb_reg[1]}}, {8{wStrb_reg[0]}}};

	always_ff @(posedge clk) begin
		if (srst) begin
			awHave_reg <= 1'b0;
			awAddr_reg <= '0;
		end else if (axiReq.awvalid && axiRsp.awready) begin
			awHave_reg <= 1'b1;
			awAddr_reg <= axiReq.awaddr;
		end else if (doWrite) begin
			awHave_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			wHave_reg <= 1'b0;
			wData_reg <= '0;
			wStrb_reg <= '0;
		end else if (axiReq.wvalid && axiRsp.wready) begin
			wHave_reg <= 1'b1;
			wData_reg <= axiReq.wdata;
			wStrb_reg <= axiReq.wstrb;
		end else if (doWrite) begin
			wHave_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			bValid_reg <= 1'b0;
			bResp_reg <= RESP_OKAY;
		end else if (doWrite) begin
			bValid_reg <= 1'b1;
			bResp_reg <= wrHit ? RESP_OKAY : RESP_SLVERR;
		end else if (axiReq.bready) begin
			bValid_reg <= 1'b0;
		end
	end

	// configuration registers
	always_ff @(posedge clk) begin
		if (srst) begin
			waveSrc_reg <= RST_BYTE;
			no_load_mode_config_reg <= RST_BYTE;
			accumulation_mode_config_reg <= RST_BYTE;
			gain_reg <= RST_GAIN;
			offset_reg <= RST_OFFSET;
			irqEnLo_reg <= RST_BYTE;
			irqEnHi_reg <= RST_BYTE;
			ctrl_reg <= RST_BYTE;
		end else if (doWrite && wrHit) begin
			unique case (wrIdx)
				IDX_WAVE_SRC: waveSrc_reg <= 8'(merge(32'(waveSrc_reg),
					wrMask, wData_reg));
				IDX_NL_MODE: no_load_mode_config_reg <= 8'(merge(32'(no_load_mode_config_reg),
					wrMask, wData_reg));
				IDX_ACC_MODE: accumulation_mode_config_reg <= 8'(merge(32'(accumulation_mode_config_reg),
					wrMask, wData_reg));
				IDX_GAIN: gain_reg <= 12'(merge(32'(gain_reg),
					wrMask, wData_reg));
				IDX_OFFSET: offset_reg <= 16'(merge(32'(offset_reg),
					wrMask, wData_reg));
				IDX_IRQ_EN_LO: irqEnLo_reg <= 8'(merge(32'(irqEnLo_reg),
					wrMask, wData_reg));
				IDX_IRQ_EN_HI: irqEnHi_reg <= 8'(merge(32'(irqEnHi_reg),
					wrMask, wData_reg));
				IDX_CTRL: ctrl_reg <= 8'(merge(32'(ctrl_reg),
					wrMask, wData_reg));
				default: ;
			endcase
		end
	end

	// datapath
	logic signed [SMP_W-1:0] currPrev_reg;
	logic signed [PWR_W-1:0] integ_reg;
	logic signed [PWR_W-1:0] shifted;
	logic signed [PWR_W-1:0] currExt;
	logic signed [SMP_W:0] currDiff;
	logic signed [MW-1:0] prodFull;
	logic signed [PWR_W-1:0] prod_reg;
	logic signed [PWR_W-1:0] lpf_reg;
	logic signed [PWR_W:0] lpfStep;
	logic signed [PWR_W+11:0] gainProd;
	logic signed [PWR_W-1:0] gained;
	logic signed [PWR_W+OFFS_FRAC-1:0] scaled;
	logic signed [PWR_W-1:0] power_reg;
	logic v1_reg;
	logic v2_reg;
	logic v3_reg;
	logic integOn;

	assign integOn = ctrl_reg[CTRL_INTEG_BIT];
	assign currExt = PWR_W'(smpIn.curr);
	assign currDiff = (SMP_W+1)'(smpIn.curr) - (SMP_W+1)'(currPrev_reg);

	// R7: lag by leaky integral, lead by difference
	always_comb begin
		if (integOn)
			shifted = integ_reg;
		else
			shifted = PWR_W'(currDiff);
	end

	// R1: voltage times shifted current
	assign prodFull = MW'(smpIn.volt) * MW'(shifted);

	always_ff @(posedge clk) begin
		if (srst) begin
			currPrev_reg <= '0;
			integ_reg <= '0;
			prod_reg <= '0;
			v1_reg <= 1'b0;
		end else begin
			v1_reg <= smpIn.valid;
			if (smpIn.valid) begin
				currPrev_reg <= smpIn.curr;
				integ_reg <= integ_reg + currExt - (integ_reg >>> INT_SHIFT);
				// R8: lagging path inverts, so flip it back
				if (integOn)
					prod_reg <= -prodFull[MW-1 -: PWR_W];
				else
					prod_reg <= prodFull[MW-1 -: PWR_W];
			end
		end
	end

	// R2: single-pole low-pass, same shape as the active power filter
	assign lpfStep = ((PWR_W+1)'(prod_reg) - (PWR_W+1)'(lpf_reg)) >>>
		LPF_SHIFT;

	always_ff @(posedge clk) begin
		if (srst) begin
			lpf_reg <= '0;
			v2_reg <= 1'b0;
		end else begin
			v2_reg <= v1_reg;
			if (v1_reg)
				lpf_reg <= lpf_reg + PWR_W'(lpfStep);
		end
	end

	// R4: y + y*gain/4096
	assign gainProd = (PWR_W+12)'(lpf_reg) *
		(PWR_W+12)'($signed(gain_reg));
	assign gained = lpf_reg + gainProd[PWR_W+11:GAIN_FRAC];
	// R5: offset added with eight fraction bits
	assign scaled = {gained, {OFFS_FRAC{1'b0}}} +
		(PWR_W+OFFS_FRAC)'($signed(offset_reg));

	always_ff @(posedge clk) begin
		if (srst) begin
			power_reg <= '0;
			v3_reg <= 1'b0;
		end else begin
			v3_reg <= v2_reg;
			// R6: drop eight fraction bits, 256 counts per LSB
			if (v2_reg)
				power_reg <= scaled[PWR_W+OFFS_FRAC-1:OFFS_FRAC];
		end
	end

	// sign change: zero counts as positive
	logic prevNeg_reg;
	logic signKnown_reg;
	logic signEvent;
	logic curNeg;

	assign curNeg = power_reg[PWR_W-1];
	// R9: direction chosen by polarity bit
	always_comb begin
		if (accumulation_mode_config_reg[SIGN_POL_BIT])
			// R11: negative to positive
			signEvent = v3_reg && signKnown_reg && prevNeg_reg && !curNeg;
		else
			// R10: positive to negative
			signEvent = v3_reg && signKnown_reg && !prevNeg_reg && curNeg;
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			prevNeg_reg <= 1'b0;
			signKnown_reg <= 1'b0;
		end else if (v3_reg) begin
			prevNeg_reg <= curNeg;
			signKnown_reg <= 1'b1;
		end
	end

	// no-load detection
	logic [PWR_W-1:0] powerAbs;
	logic [PWR_W-1:0] threshold;
	logic noLoad_reg;

	assign powerAbs = curNeg ? PWR_W'(-power_reg) : PWR_W'(power_reg);

	// R15: threshold select
	always_comb begin
		unique case (no_load_mode_config_reg[NL_SEL_LO +: 2])
			2'h1: threshold = THR_1;
			2'h2: threshold = THR_2;
			2'h3: threshold = THR_3;
			default: threshold = '0;
		endcase
	end

	always_ff @(posedge clk) begin
		if (srst)
			noLoad_reg <= 1'b0;
		else if (v3_reg)
			noLoad_reg <= powerAbs < threshold;
	end

	// R13: no accumulation while under threshold
	assign accumEnable = !noLoad_reg;

	// R16: sticky flags, write one to clear, set beats clear
	always_comb begin
		status_next = status_reg;
		if (doWrite && wrHit && wrIdx == IDX_IRQ_ST_LO)
			status_next = status_reg & ~(wData_reg[7:0] & wrMask[7:0]);
		if (signEvent)
			status_next[ST_SIGN_BIT] = 1'b1;
		// R14: level condition keeps setting the flag
		if (noLoad_reg)
			status_next[ST_NOLOAD_BIT] = 1'b1;
	end

	always_ff @(posedge clk) begin
		if (srst)
			status_reg <= RST_BYTE;
		else
			status_reg <= status_next & ST_IMPL_MASK;
	end

	// R12: masked flags hold the interrupt
	assign irq = |(status_reg & irqEnLo_reg);

	// waveform sample rate: base tick then octave division
	logic [8:0] baseCnt_reg;
	logic [2:0] octCnt_reg;
	logic baseTick;
	logic [2:0] rateMask;
	logic waveTick;

	assign baseTick = (baseCnt_reg == WAVE_BASE_LAST);

	always_ff @(posedge clk) begin
		if (srst) begin
			baseCnt_reg <= '0;
			octCnt_reg <= '0;
		end else if (baseTick) begin
			baseCnt_reg <= '0;
			octCnt_reg <= octCnt_reg + 3'h1;
		end else begin
			baseCnt_reg <= baseCnt_reg + 9'h001;
		end
	end

	always_comb begin
		unique case (waveSrc_reg[WAVE_RATE_LO +: 2])
			2'h0: rateMask = 3'h0;
			2'h1: rateMask = 3'h1;
			2'h2: rateMask = 3'h3;
			default: rateMask = 3'h7;
		endcase
	end

	assign waveTick = baseTick && ((octCnt_reg & rateMask) == 3'h0);

	// R3: reactive source and sampling enable both needed
	always_ff @(posedge clk) begin
		if (srst) begin
			waveOut <= '0;
		end else begin
			waveOut.valid <= waveTick && irqEnHi_reg[WAVE_EN_BIT] &&
				(waveSrc_reg[WAVE_SRC_LO +: 3] == WAVE_SRC_REACTIVE);
			if (waveTick)
				waveOut.data <= power_reg;
		end
	end

	// bus read channel
	always_comb begin
		rdHit = addrHit(axiReq.araddr);
		unique case (axiReq.araddr[9:2])
			IDX_WAVE_SRC: rdValue = 32'(waveSrc_reg);
			IDX_NL_MODE: rdValue = 32'(no_load_mode_config_reg);
			IDX_ACC_MODE: rdValue = 32'(accumulation_mode_config_reg);
			IDX_GAIN: rdValue = 32'(gain_reg);
			IDX_OFFSET: rdValue = 32'(offset_reg);
			IDX_IRQ_EN_LO: rdValue = 32'(irqEnLo_reg);
			IDX_IRQ_EN_HI: rdValue = 32'(irqEnHi_reg);
			IDX_IRQ_ST_LO: rdValue = 32'(status_reg);
			IDX_CTRL: rdValue = 32'(ctrl_reg);
			IDX_POWER: rdValue = 32'(power_reg);
			default: rdValue = 32'h00000000;
		endcase
		if (!rdHit)
			rdValue = 32'h00000000;
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			rValid_reg <= 1'b0;
			rData_reg <= '0;
			rResp_reg <= RESP_OKAY;
		end else if (axiReq.arvalid && axiRsp.arready) begin
			rValid_reg <= 1'b1;
			rData_reg <= rdValue;
			rResp_reg <= rdHit ? RESP_OKAY : RESP_SLVERR;
		end else if (axiReq.rready) begin
			rValid_reg <= 1'b0;
		end
	end

	always_comb begin
		axiRsp.awready = !awHave_reg && !bValid_reg;
		axiRsp.wready = !wHave_reg && !bValid_reg;
		axiRsp.bvalid = bValid_reg;
		axiRsp.bresp = bResp_reg;
		axiRsp.arready = !rValid_reg;
		axiRsp.rvalid = rValid_reg;
		axiRsp.rdata = rData_reg;
		axiRsp.rresp = rResp_reg;
	end
endmodule : rpd_reactive_power

// ==== rpd_monitor.sv ====
/* Checker on the reactive power datapath top ports, bound below.
 * Assumes one clock domain and a synchronous active-high reset. */
`timescale 1ns/1ps
module rpd_monitor (
	input wire logic clk, // clock
	input wire logic srst, // sync reset
	input wire rpd_pkg::rpd_axil_req_s axiReq, // bus request
	input wire rpd_pkg::rpd_axil_rsp_s axiRsp, // bus response
	input wire rpd_pkg::rpd_smp_s smpIn, // samples
	input wire rpd_pkg::rpd_wave_s waveOut, // waveform
	input wire logic accumEnable, // may accumulate
	input wire logic irq // interrupt
);
	import rpd_pkg::*;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);
	logic [11:0] gap;
	logic seen;
	// saturates so a long idle span never wraps to a small gap
	always_ff @(posedge clk) begin
		if (srst || waveOut.valid)
			gap <= 12'h000;
		else if (gap != 12'hfff)
			gap <= gap + 12'h001;
	end
	always_ff @(posedge clk) begin
		if (srst)
			seen <= 1'b0;
		else if (waveOut.valid)
			seen <= 1'b1;
	end
	sequence wrTaken;
		axiReq.awvalid && axiRsp.awready && axiReq.wvalid && axiRsp.wready;
	endsequence
	sequence wrAnswer;
		!axiRsp.awready ##1 axiRsp.bvalid;
	endsequence
	chk_write_answer: assert property (wrTaken |=> wrAnswer)
		else $error("write answer late");
	chk_bad_address: assert property ((wrTaken ##0 axiReq.awaddr == 12'h004)
		|=> ##1 axiRsp.bresp == RESP_SLVERR) else $error("no error response");
	chk_read_answer: assert property (axiReq.arvalid && axiRsp.arready
		|=> axiRsp.rvalid && !axiRsp.arready) else $error("read answer late");
	chk_write_block: assert property (axiRsp.bvalid
		|-> !axiRsp.awready && !axiRsp.wready) else $error("write not held");
	chk_wave_pulse: assert property (
		waveOut.valid |=> !waveOut.valid) else $error("wave pulse too long");
	chk_wave_spacing: assert property (
		waveOut.valid && seen |-> gap >= 12'h185) else $error("wave too fast");
	chk_reset_idle: assert property ($fell(srst)
		|-> !irq && accumEnable && !axiRsp.bvalid) else $error("bad reset");
	chk_irq_cause: assert property ($rose(irq) |-> axiRsp.bvalid ||
		$past(axiRsp.bvalid) || $past(smpIn.valid, 4) ||
		$past(smpIn.valid, 5)) else $error("interrupt without cause");
	chk_irq_release: assert property ($fell(irq) |-> axiRsp.bvalid)
		else $error("interrupt dropped without a write");
endmodule : rpd_monitor

bind rpd_reactive_power rpd_monitor chkI (.clk(clk), .srst(srst),
	.axiReq(axiReq), .axiRsp(axiRsp), .smpIn(smpIn), .waveOut(waveOut),
	.accumEnable(accumEnable), .irq(irq));

// ==== rpd_sample_src.sv ====
/* Upstream sample source: voltage and current from an eight-step sine,
 * voltage leading by a set number of steps. Assumes one pair per strobe. */
`timescale 1ns/1ps
module rpd_sample_src #(
	parameter int GAP = 8
) (
	input wire logic clk, // clock
	input wire logic srst, // sync reset
	input wire logic [2:0] lead, // voltage lead, eighths
	input wire logic live, // low sends zeros
	output rpd_pkg::rpd_smp_s smp // sample pair
);
	import rpd_pkg::*;
	localparam logic [23:0] SINE [8] = '{24'h000000, 24'h43e000,
		24'h600000, 24'h43e000, 24'h000000, 24'hbc2000, 24'ha00000,
		24'hbc2000};
	logic [7:0] cnt;
	logic [2:0] k;
	always_ff @(posedge clk) begin
		if (srst || cnt == 8'(GAP - 1))
			cnt <= 8'h00;
		else
			cnt <= cnt + 8'h01;
	end
	always_ff @(posedge clk) begin
		if (srst) begin
			k <= 3'h0;
			smp <= '0;
		end else if (cnt == 8'(GAP - 1)) begin
			k <= k + 3'h1;
			smp.valid <= 1'b1;
			smp.volt <= live ? SINE[3'(k + lead)] : 24'h000000;
			smp.curr <= live ? SINE[k] : 24'h000000;
		end else begin
			// off the strobe the lines toggle every clock, alternating the inverted and the stale value
			smp.valid <= 1'b0;
			smp.volt <= ~smp.volt;
			smp.curr <= ~smp.curr;
		end
	end
endmodule : rpd_sample_src

// ==== tb_top.sv ====
/* Self-checking bench: AXI4-Lite register tasks, sample source, checker.
 * Assumes a 10 MHz clock and a synchronous active-high reset. */
`timescale 1ns/1ps
module tb_top;
	import rpd_pkg::*;
	localparam logic [7:0] REGS [9] = '{IDX_WAVE_SRC, IDX_NL_MODE,
		IDX_ACC_MODE, IDX_GAIN, IDX_OFFSET, IDX_IRQ_EN_LO, IDX_IRQ_EN_HI,
		IDX_IRQ_ST_LO, IDX_CTRL};
	localparam logic [31:0] OFS [3] = '{32'h100, 32'hff00, 32'hffff0300};
	localparam logic [31:0] PWR [3] = '{32'h1, 32'hffffffff, 32'h3};
	logic clk = 1'b0;
	logic srst = 1'b1;
	rpd_axil_req_s req = '0;
	rpd_axil_rsp_s rsp;
	rpd_smp_s smp;
	rpd_wave_s wave;
	logic accEn;
	logic irq;
	logic [2:0] lead = 3'h2;
	logic live = 1'b0;
	logic [31:0] d;
	logic [1:0] resp;
	int nFail = 0;
	int compares = 0;
	int c;
	int p;

	always #50 clk = ~clk;

	rpd_reactive_power #(.LPF_SHIFT(5)) uut (.clk(clk), .srst(srst),
		.axiReq(req), .axiRsp(rsp), .smpIn(smp), .waveOut(wave),
		.accumEnable(accEn), .irq(irq));
	rpd_sample_src src (.clk(clk), .srst(srst), .lead(lead), .live(live),
		.smp(smp));

	task automatic printVerdict;
		if (nFail == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : printVerdict

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] s);
		compares++;
		if (s !== e) begin
			nFail++;
			$display("unexpected %s: expected %h, seen %h", nm, e, s);
		end
	endtask : chk

	task automatic wt(input int n);
		repeat (n) @(posedge clk);
	endtask : wt

	task automatic wr(input logic [7:0] ix, input logic [31:0] v);
		req.awaddr <= 12'({ix, 2'b00});
		req.wdata <= v;
		req.wstrb <= 4'hf;
		req.awvalid <= 1'b1;
		req.wvalid <= 1'b1;
		req.bready <= 1'b1;
		do begin
			@(posedge clk);
			if (rsp.awready) req.awvalid <= 1'b0;
			if (rsp.wready) req.wvalid <= 1'b0;
		end while (rsp.bvalid !== 1'b1);
		resp = rsp.bresp;
		req.bready <= 1'b0;
		@(posedge clk);
	endtask : wr

	task automatic rd(input logic [7:0] ix);
		req.araddr <= 12'({ix, 2'b00});
		req.arvalid <= 1'b1;
		req.rready <= 1'b1;
		do begin
			@(posedge clk);
			if (rsp.arready) req.arvalid <= 1'b0;
		end while (rsp.rvalid !== 1'b1);
		d = rsp.rdata;
		resp = rsp.rresp;
		req.rready <= 1'b0;
		@(posedge clk);
	endtask : rd

	task automatic rc(input logic [7:0] ix, input logic [31:0] e,
		input string nm);
		rd(ix);
		chk(nm, e, d);
	endtask : rc

	task automatic wp(input int lim);
		c = 0;
		do begin
			@(posedge clk);
			c++;
		end while (wave.valid !== 1'b1 && c < lim);
	endtask : wp

	initial begin
		wt(12);
		srst <= 1'b0;
		wt(1);
		foreach (REGS[i])
			rc(REGS[i], 32'h0, "reset value");
		rd(8'h01);
		chk("unmapped read", {30'h0, RESP_SLVERR}, {30'h0, resp});
		wr(8'h01, 32'hffffffff);
		chk("unmapped write", {30'h0, RESP_SLVERR}, {30'h0, resp});
		wr(IDX_POWER, 32'h1234);
		rc(IDX_POWER, 32'h0, "power read only");
		wr(IDX_GAIN, 32'hffffffff);
		rc(IDX_GAIN, 32'hfff, "gain width");
		wr(IDX_GAIN, 32'h0);
		// zero input, so the power is the offset alone
		for (int i = 0; i < 3; i++) begin
			wr(IDX_OFFSET, OFS[i]);
			wt(40);
			rc(IDX_POWER, PWR[i], "offset power");
		end
		rc(IDX_OFFSET, 32'h300, "offset width");
		wr(IDX_OFFSET, 32'h0);
		wr(IDX_IRQ_EN_LO, 32'h2);
		for (int s = 0; s < 4; s++) begin
			wr(IDX_NL_MODE, 32'(s << 2));
			wt(40);
			wr(IDX_IRQ_ST_LO, 32'h12);
			wt(40);
			rc(IDX_IRQ_ST_LO, (s > 0) ? 32'h2 : 32'h0, "no-load flag");
			chk("accum enable", 32'(s == 0), 32'(accEn));
			chk("irq no-load", 32'(s > 0), 32'(irq));
		end
		wr(IDX_NL_MODE, 32'h0);
		live <= 1'b1;
		wt(3200);
		rd(IDX_IRQ_ST_LO);
		chk("sticky no-load", 32'h2, d & 32'h2);
		wr(IDX_IRQ_ST_LO, 32'h12);
		chk("irq cleared", 32'h0, 32'(irq));
		for (int i = 0; i < 4; i++) begin
			wr(IDX_CTRL, 32'(i / 2));
			lead <= i[0] ? 3'h6 : 3'h2;
			wt(3200);
			rd(IDX_POWER);
			chk("power sign", 32'(i[0]), 32'(d[31]));
		end
		// gain code 0x800 is minus one half
		p = $signed(d);
		wr(IDX_GAIN, 32'h800);
		wt(400);
		rd(IDX_POWER);
		c = 2 * $signed(d) - p;
		chk("gain half", 32'h1, 32'((c < 0 ? -c : c) < -p / 8));
		wr(IDX_GAIN, 32'h0);
		// ripple can cross zero twice; offsets alone give a clean swing
		live <= 1'b0;
		wt(3200);
		wr(IDX_IRQ_EN_LO, 32'h10);
		for (int i = 0; i < 4; i++) begin
			wr(IDX_ACC_MODE, 32'(i / 2) << 5);
			wr(IDX_IRQ_ST_LO, 32'h12);
			// plus or minus 64 output counts, well above filter residue
			wr(IDX_OFFSET, i[0] ? 32'h0000c000 : 32'h00004000);
			wt(40);
			rc(IDX_IRQ_ST_LO, 32'(i[0] ^ i[1]) << 4, "sign flag");
			chk("irq sign", 32'(i[0] ^ i[1]), 32'(irq));
			if (i == 2) begin
				wr(IDX_IRQ_EN_LO, 32'h0);
				chk("irq masked", 32'h0, 32'(irq));
				wr(IDX_IRQ_EN_LO, 32'h10);
			end
		end
		wr(IDX_IRQ_EN_HI, 32'h20);
		for (int r = 0; r < 4; r++) begin
			wr(IDX_WAVE_SRC, 32'(r << 3) | 32'h5);
			// first pulse after a rate change may be short
			wp(8000);
			wp(8000);
			chk("wave interval", 32'(WAVE_BASE_DIV << r), 32'(c));
			chk("wave sign", 32'h1, 32'(wave.data[31]));
		end
		wr(IDX_IRQ_EN_HI, 32'h0);
		wp(1000);
		chk("wave off", 32'h3e8, 32'(c));
		printVerdict();
	end

	initial begin
		wt(90000);
		nFail++;
		printVerdict();
	end
endmodule : tb_top
